/* dcap_bench.sv */
`timescale 1ns/1ps
// ============================================================
// Both ends joined back to back, driven from the controller side
module dcap_bench;
    localparam logic [6:0] ADDR = 7'h54; // Select code with strap low
    logic               clk_sys = 1'b0;
    logic               reset_n;
    logic               req_valid;
    logic               req_ready;
    dcap_pkg::dcap_op_e req_op;
    logic [6:0]         req_addr;
    logic [1:0]         req_nib;
    logic [8:0]         req_code;
    logic               done;
    logic               nack;
    logic [31:0]        rd_data;
    logic [8:0]         capacitor_code;
    logic               nv_mode;
    logic [8:0]         volatile_code_reg;
    logic [8:0]         stored_code_mem;
    int                 err_count = 0;
    int                 cmp_count = 0;
    int                 cyc = 0;
    dcap_if bus_if ();
    dcap_dev u_dcap_dev (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus_if),
        .addr_lsb(1'b0), .capacitor_code(capacitor_code), .nv_mode(nv_mode),
        .volatile_code_reg(volatile_code_reg), .stored_code_mem(stored_code_mem));
    dcap_ctl u_dcap_ctl (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus_if),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_addr(req_addr), .req_nib(req_nib), .req_code(req_code),
        .done(done), .nack(nack), .rd_data(rd_data));
    dcap_props u_dcap_props (.clk_sys(clk_sys), .reset_n(reset_n),
        .scl_o(bus_if.scl_o), .scl_oe(bus_if.scl_oe), .sda_m_o(bus_if.sda_m_o),
        .sda_m_oe(bus_if.sda_m_oe), .sda_s_o(bus_if.sda_s_o),
        .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl), .sda(bus_if.sda));
    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;
    // Ceiling covers four 5 ms programming waits plus short frames
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 600000) begin
            err_count++;
            end_sim();
        end
    end
    // Compare and report
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One command, inputs moved on falling edges, bounded wait for done
    task automatic do_cmd(input dcap_pkg::dcap_op_e op, input logic [6:0] addr,
                          input logic [8:0] code, input logic exp_nack);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        req_op = op;
        req_addr = addr;
        req_code = code;
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 200000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        repeat (4) @(negedge clk_sys);
        chk("nack", {31'h0, nack}, {31'h0, exp_nack});
    endtask : do_cmd
    // Verdict, reached from the main sequence or the ceiling
    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        req_valid = 1'b0;
        req_op = dcap_pkg::DCAP_OP_READ;
        req_addr = ADDR;
        req_nib = 2'h0;
        req_code = 9'h000;
        reset_n = 1'b0;
        repeat (16) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (30) @(negedge clk_sys);
        chk("volatile after reset", volatile_code_reg, 32'h0);
        do_cmd(dcap_pkg::DCAP_OP_READ, ADDR, 9'h000, 1'b0);
        // Last-nibble field, cleared to zero by reset, is masked
        chk("status byte", rd_data[31:24] & 8'hf9, 32'h80);
        chk("read low bytes", rd_data[23:0], 32'h000400);
        do_cmd(dcap_pkg::DCAP_OP_VWRITE, ADDR, 9'h125, 1'b0);
        chk("volatile reg", volatile_code_reg, 32'h125);
        chk("setting volatile", capacitor_code, 32'h125);
        // Mode-set sends zeros in the ignored bits; the all-ones code is not used
        do_cmd(dcap_pkg::DCAP_OP_SETNV, ADDR, 9'h1ff, 1'b0);
        chk("mode after set", {31'h0, nv_mode}, 32'h1);
        chk("setting stored", capacitor_code, 32'h0);
        chk("volatile kept", volatile_code_reg, 32'h125);
        do_cmd(dcap_pkg::DCAP_OP_NVWRITE, ADDR, 9'h000, 1'b0);
        do_cmd(dcap_pkg::DCAP_OP_NVWRITE, ADDR, 9'h005, 1'b0);
        chk("memory nibble", stored_code_mem, 32'h005);
        req_nib = 2'h2;
        do_cmd(dcap_pkg::DCAP_OP_NVWRITE, ADDR, 9'h000, 1'b0);
        do_cmd(dcap_pkg::DCAP_OP_NVWRITE, ADDR, 9'h001, 1'b0);
        chk("memory top nibble", stored_code_mem, 32'h105);
        chk("no copy before read", capacitor_code, 32'h0);
        do_cmd(dcap_pkg::DCAP_OP_READ, ADDR, 9'h000, 1'b0);
        chk("read bytes", rd_data, 32'h8d250505);
        chk("copy on read", capacitor_code, 32'h105);
        do_cmd(dcap_pkg::DCAP_OP_VWRITE, ADDR, 9'h0a3, 1'b0);
        chk("back to volatile", {31'h0, nv_mode}, 32'h0);
        chk("setting follows reg", capacitor_code, 32'h0a3);
        // Strap is low, so the odd select code belongs to nobody
        do_cmd(dcap_pkg::DCAP_OP_VWRITE, 7'h55, 9'h111, 1'b1);
        chk("foreign write ignored", volatile_code_reg, 32'h0a3);
        end_sim();
    end
endmodule : dcap_bench

/* dcap_ctl.sv */
`timescale 1ns/1ps
`include "dcap_map.svh"
module dcap_ctl (
    input  wire logic                 clk_sys,    // System clock
    input  wire logic                 reset_n,    // Synchronous reset, active low
    dcap_if.ctl                       bus,        // Two-wire bus
    input  wire logic                 req_valid,  // Command request
    output logic                      req_ready,  // Idle, may take request
    input  wire dcap_pkg::dcap_op_e   req_op,     // Operation
    input  wire logic [6:0]           req_addr,   // Device select code
    input  wire logic [1:0]           req_nib,    // Nibble for non-volatile write
    input  wire logic [8:0]           req_code,   // Code or nibble data
    output logic                      done,       // Command finished pulse
    output logic                      nack,       // Device did not acknowledge
    output logic [31:0]               rd_data     // Four read bytes, first in MSB
);
    // ==========================================================
    // Clock divider: one enable per half SCL period
    // SCL at most 400 kHz, 50% duty
    logic [7:0] div_q;
    logic       tick;
    assign tick = div_q == 8'((`DCAP_SCL_HALF_CYC) - 1);
    always_ff @(posedge clk_sys) begin
        if (!reset_n || tick) div_q <= 8'h00;
        else                  div_q <= div_q + 8'h01;
    end
    typedef enum logic [2:0] {C_IDLE, C_START, C_BIT, C_WAIT, C_STOP, C_END} dcap_cst_e;
    dcap_cst_e   st_q;
    logic [26:0] frame_q;     // Bits to send, MSB first
    logic [5:0]  nbits_q;
    logic [5:0]  idx_q;
    logic        ph_q;        // 0 = SCL low phase, 1 = high
    logic        rd_q, nv_q, nack_q;
    logic [17:0] wait_q;
    logic        scl_q, sda_q;
    logic [7:0]  hi_b, lo_b;
    // Command bytes by operation
    // Nibble patterns
    always_comb begin
        hi_b = 8'h00;
        lo_b = 8'h00;
        case (req_op)
            dcap_pkg::DCAP_OP_VWRITE: begin
                hi_b = {7'h00, req_code[8]};
                lo_b = req_code[7:0];
            end
            dcap_pkg::DCAP_OP_NVWRITE: begin
                hi_b = {1'b1, req_nib, 5'h00};
                lo_b = (req_nib == 2'h2) ? {7'h00, req_code[0]} : {4'h0, req_code[3:0]};
            end
            dcap_pkg::DCAP_OP_SETNV: hi_b = {`DCAP_SETNV_PATTERN, 4'h0};
            default: ;
        endcase
    end
    assign req_ready = st_q == C_IDLE;
    // Bit sequencer: address, acks, bytes; sda_q is the released level
    always_ff @(posedge clk_sys) begin
        done <= 1'b0;
        if (!reset_n) begin
            st_q <= C_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; nack <= 1'b0; rd_data <= 32'h0;
        end else case (st_q)
            C_IDLE: if (req_valid) begin
                rd_q  <= req_op == dcap_pkg::DCAP_OP_READ;
                nv_q  <= req_op == dcap_pkg::DCAP_OP_NVWRITE;
                frame_q <= {req_addr, req_op == dcap_pkg::DCAP_OP_READ, 1'b1,
                            hi_b, 1'b1, lo_b, 1'b1};
                nbits_q <= (req_op == dcap_pkg::DCAP_OP_READ) ? 6'd45 : 6'd27;
                idx_q <= 6'h00; nack_q <= 1'b0; ph_q <= 1'b0;
                st_q  <= C_START;
            end
            C_START: if (tick) begin
                sda_q <= 1'b0;
                st_q  <= C_BIT;
            end
            C_BIT: if (tick) begin
                // First fall after start is not a bit phase, so the phase holds
                if (ph_q || !scl_q) ph_q <= ~ph_q;
                if (!ph_q) begin
                    if (scl_q) scl_q <= 1'b0;
                    else begin
                        // Drive next bit; in read phase release except for acks
                        if (idx_q < 6'd9 || !rd_q) sda_q <= frame_q[26 - 5'(idx_q)];
                        else sda_q <= ((idx_q - 6'd9) % 6'd9 == 6'd8) ? (idx_q == 6'd44) : 1'b1;
                        scl_q <= 1'b1;
                    end
                end else begin
                    if (((!rd_q && (idx_q == 6'd8 || idx_q == 6'd17 || idx_q == 6'd26))
                         || (rd_q && idx_q == 6'd8)) && bus.sda) nack_q <= 1'b1;
                    if (rd_q && idx_q >= 6'd9 && ((idx_q - 6'd9) % 6'd9) != 6'd8)
                        rd_data <= {rd_data[30:0], bus.sda};
                    scl_q <= 1'b0;
                    idx_q <= idx_q + 6'h01;
                    if (idx_q == nbits_q - 6'h01) begin
                        sda_q  <= 1'b0;
                        wait_q <= 18'h0;
                        st_q   <= (nv_q && !nack_q && !bus.sda) ? C_WAIT : C_STOP;
                    end
                end
            end
            C_WAIT: begin
                wait_q <= wait_q + 18'h1;
                if (wait_q == 18'(`DCAP_NV_PROG_CYC - 1)) st_q <= C_STOP;
            end
            C_STOP: if (tick) begin
                if (!scl_q) scl_q <= 1'b1;
                else begin sda_q <= 1'b1; st_q <= C_END; end
            end
            default: begin
                nack <= nack_q; done <= 1'b1; st_q <= C_IDLE;
            end
        endcase
    end
    assign bus.scl_o    = 1'b0;
    assign bus.scl_oe   = ~scl_q;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = ~sda_q;
endmodule : dcap_ctl

/* dcap_dev.sv */
`timescale 1ns/1ps
`include "dcap_map.svh"
// Functional notes
// - Mode-set write enters non-volatile mode
// - Mode-set recognised when upper nibble 0x9
// - High byte: target, nibble, set-mode bits
// - Mode-set ignores low nibble, low byte
// - Non-volatile mode uses stored-code register
// - Stored code copied on read or reset
// - Mode-set leaves volatile register alone
// - Reset clears volatile register
// - Controller clock at most 400 kHz
// - Controller waits 5 ms before stop
// - Volatile write changes setting immediately
// - Three writes store full nine-bit code
// - Erase nibble with 0x0 before programming
// - Read, then mode-set after programming
// - Volatile mode ignores programming until mode-set
// - Other erase/write orders allowed
// - Nibble patterns 1100, 1010, 1000
// - Read returns four bytes, MSB first
// - Volatile code bit 8 in high LSB
// - Interval from post-ack fall to stop
module dcap_dev (
    input  wire logic                clk_sys,     // System clock
    input  wire logic                reset_n,     // Synchronous reset, active low
    dcap_if.dev                      bus,         // Two-wire bus
    input  wire logic                addr_lsb,    // Device select code LSB strap
    output logic [8:0]               capacitor_code, // Active capacitor setting
    output logic                     nv_mode,     // 1 = non-volatile mode
    output logic [8:0]               volatile_code_reg, // Volatile register
    output logic [8:0]               stored_code_mem    // Non-volatile memory
);
    // Upper six bits of the device select code; arbitrary value
    parameter logic [5:0] DEVICE_SELECT_CODE = 6'h2a;
    // ==========================================================
    // Synchronisers and edge detect
    logic [1:0] scl_s_q, sda_s_q;
    logic       scl_p_q, sda_p_q;
    always_ff @(posedge clk_sys) begin
        scl_s_q <= {scl_s_q[0], bus.scl};
        sda_s_q <= {sda_s_q[0], bus.sda};
        scl_p_q <= scl_s_q[1];
        sda_p_q <= sda_s_q[1];
    end
    logic scl_l, sda_l, scl_rise, scl_fall, start_c, stop_c;
    assign scl_l    = scl_s_q[1];
    assign sda_l    = sda_s_q[1];
    assign scl_rise = scl_l & ~scl_p_q;
    assign scl_fall = ~scl_l & scl_p_q;
    assign start_c  = scl_l & scl_p_q & sda_p_q & ~sda_l;
    assign stop_c   = scl_l & scl_p_q & ~sda_p_q & sda_l;
    // ==========================================================
    // Byte engine
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_TXACK} dcap_st_e;
    dcap_st_e   st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [1:0] byte_q;        // Byte index within transfer
    logic       rd_q;          // Transfer is a read
    logic [7:0] cfg1_q;
    logic       cmd_ready_q;   // Low byte received, its acknowledge not yet clocked
    logic       sda_drv_q;     // Drive data low
    logic       rx_done;
    logic [1:0] last_nib_q;
    logic [8:0] nv_ctl_q;      // Non-volatile control register
    logic       load_nv_q;     // Copy memory after reset
    logic [7:0] tx_byte;
    // Memory cells keep their content over reset; power-up content is zero here
    logic [8:0] nv_mem_q = 9'h000;
    assign rx_done = scl_rise && bit_q == 4'h7;
    // Read-out byte selection, most significant first
    // Four read bytes
    always_comb begin
        case (byte_q)
            2'h0:    tx_byte = {`DCAP_RD_B3_TOP, nv_mode, last_nib_q, volatile_code_reg[8]};
            2'h1:    tx_byte = volatile_code_reg[7:0];
            2'h2:    tx_byte = {`DCAP_RD_B1_TOP, addr_lsb, `DCAP_RD_B1_FIX, stored_code_mem[8]};
            default: tx_byte = stored_code_mem[7:0];
        endcase
    end
    // Protocol state machine; start or stop resets framing from any state
    always_ff @(posedge clk_sys) begin
        if (!reset_n || stop_c) begin
            st_q      <= S_IDLE;
            sda_drv_q <= 1'b0;
            bit_q     <= 4'h0;
        end else if (start_c) begin
            st_q      <= S_ADDR;
            bit_q     <= 4'h0;
            byte_q    <= 2'h0;
            sda_drv_q <= 1'b0;
        end else begin
            case (st_q)
                S_ADDR, S_RX: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_l};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (st_q == S_ADDR) begin
                            if (sh_q[7:1] == {DEVICE_SELECT_CODE, addr_lsb}) begin
                                rd_q      <= sh_q[0];
                                sda_drv_q <= 1'b1;
                                st_q      <= S_ACK;
                            end else begin
                                st_q <= S_IDLE;
                            end
                        end else begin
                            sda_drv_q <= 1'b1;
                            st_q      <= S_ACK;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        sda_drv_q <= 1'b0;
                        if (rd_q) begin
                            st_q      <= S_TX;
                            sda_drv_q <= ~tx_byte[7];
                            sh_q      <= {tx_byte[6:0], 1'b0};
                        end else if (byte_q == 2'h2) begin
                            st_q <= S_IDLE;
                        end else begin
                            st_q <= S_RX;
                        end
                        if (!rd_q) begin
                            byte_q <= byte_q + 2'h1;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h6) begin
                            sda_drv_q <= ~sh_q[7];
                        end else if (bit_q == 4'h7) begin
                            sda_drv_q <= 1'b0;
                            st_q      <= S_TXACK;
                            bit_q     <= 4'h0;
                        end else begin
                            sda_drv_q <= ~sh_q[7];
                            sh_q      <= {sh_q[6:0], 1'b0};
                        end
                    end
                end
                S_TXACK: begin
                    if (scl_rise) begin
                        if (sda_l || byte_q == 2'h3) begin
                            st_q <= S_IDLE;
                        end else begin
                            byte_q <= byte_q + 2'h1;
                        end
                    end
                    if (scl_fall && st_q == S_TXACK) begin
                        st_q      <= S_TX;
                        sda_drv_q <= ~tx_byte[7];
                        sh_q      <= {tx_byte[6:0], 1'b0};
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
    assign bus.sda_s_o  = 1'b0;
    assign bus.sda_s_oe = sda_drv_q;
    // Capture high command byte; flag completion of low byte
    // Low byte received, as its acknowledge begins
    always_ff @(posedge clk_sys) begin
        cmd_ready_q <= 1'b0;
        if (!reset_n) begin
            cfg1_q <= 8'h00;
        end else if (st_q == S_RX && scl_fall && bit_q == 4'h8) begin
            if (byte_q == 2'h1) begin
                cfg1_q <= sh_q;
            end else begin
                cmd_ready_q <= 1'b1;
            end
        end
    end
    logic is_read_start;
    assign is_read_start = (st_q == S_ACK) && rd_q && scl_fall;
    // ==========================================================
    // Command execution
    // Clear volatile register
    // Code bit 8 in high LSB
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            volatile_code_reg <= 9'h000;
            nv_mode           <= 1'b0;
        end else if (cmd_ready_q) begin
            if (!cfg1_q[`DCAP_CMD_TGT_BIT]) begin
                volatile_code_reg <= {cfg1_q[0], sh_q};
                nv_mode           <= 1'b0;
            end else if (cfg1_q[7:4] == `DCAP_SETNV_PATTERN) begin
                nv_mode <= 1'b1;
            end
        end
    end
    // Non-volatile nibble programming, zero data is an erase
    // Nibble patterns
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            last_nib_q <= 2'h0;
        end else if (cmd_ready_q && cfg1_q[`DCAP_CMD_TGT_BIT] && !cfg1_q[`DCAP_CMD_SETNV_BIT]) begin
            last_nib_q <= cfg1_q[`DCAP_CMD_NIB_HI:`DCAP_CMD_NIB_LO];
            case (cfg1_q[7:4])
                `DCAP_NIB2_PATTERN: nv_mem_q[8]   <= sh_q[0];
                `DCAP_NIB1_PATTERN: nv_mem_q[7:4] <= sh_q[3:0];
                `DCAP_NIB0_PATTERN: nv_mem_q[3:0] <= sh_q[3:0];
                default: ;
            endcase
        end
    end
    // One driver per signal: the memory port mirrors the cells
    assign stored_code_mem = nv_mem_q;
    always_ff @(posedge clk_sys) begin
        load_nv_q <= ~reset_n;
        if (!reset_n) begin
            nv_ctl_q <= 9'h000;
        end else if (load_nv_q || is_read_start) begin
            nv_ctl_q <= stored_code_mem;
        end
    end
    assign capacitor_code = nv_mode ? nv_ctl_q : volatile_code_reg;
endmodule : dcap_dev

/* dcap_if.sv */
`timescale 1ns/1ps
interface dcap_if;
    logic scl_o;      // Clock driven by controller
    logic scl_oe;     // Controller drives clock low
    logic sda_m_o;    // Controller data out
    logic sda_m_oe;   // Controller pulls data low
    logic sda_s_o;    // Device data out
    logic sda_s_oe;   // Device pulls data low
    logic scl;        // Resolved clock level
    logic sda;        // Resolved data level
    // Open drain with pull-ups
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
    modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport ctl (input scl, input sda, output scl_o, output scl_oe,
                 output sda_m_o, output sda_m_oe);
endinterface : dcap_if

/* dcap_map.svh */
`ifndef DCAP_MAP_SVH
`define DCAP_MAP_SVH
// Bus timing: fSCL max 400 kHz, programming interval 5 ms, system clock 20 MHz
`define DCAP_CLK_HZ          20000000
`define DCAP_SCL_MAX_HZ      400000
`define DCAP_NV_PROG_MS      5
// Half period of SCL in system cycles (rounded up to stay <= 400 kHz)
`define DCAP_SCL_HALF_CYC    ((`DCAP_CLK_HZ + 2*`DCAP_SCL_MAX_HZ - 1) / (2*`DCAP_SCL_MAX_HZ))
`define DCAP_NV_PROG_CYC     ((`DCAP_CLK_HZ / 1000) * `DCAP_NV_PROG_MS)
// High command byte fields
`define DCAP_CMD_TGT_BIT     7
`define DCAP_CMD_NIB_HI      6
`define DCAP_CMD_NIB_LO      5
`define DCAP_CMD_SETNV_BIT   4
`define DCAP_SETNV_PATTERN   4'h9
// Nibble-write patterns of the high command byte upper nibble
`define DCAP_NIB2_PATTERN    4'hc
`define DCAP_NIB1_PATTERN    4'ha
`define DCAP_NIB0_PATTERN    4'h8
// Read-out constants
`define DCAP_RD_B3_TOP       4'h8
`define DCAP_RD_B1_TOP       4'h0
`define DCAP_RD_B1_FIX       2'h2
`define DCAP_READ_BYTES      4
`endif

/* dcap_pkg.sv */
package dcap_pkg;
    typedef logic [8:0] dcap_code_t;
    typedef enum logic [1:0] {
        DCAP_OP_VWRITE,
        DCAP_OP_NVWRITE,
        DCAP_OP_SETNV,
        DCAP_OP_READ
    } dcap_op_e;
endpackage : dcap_pkg

/* dcap_props.sv */
`timescale 1ns/1ps
`include "dcap_map.svh"
// ============================================================
// Wire checks on the shared two-wire bus
module dcap_props (
    input wire logic clk_sys,  // System clock
    input wire logic reset_n,  // Synchronous reset, active low
    input wire logic scl_o,    // Controller clock out
    input wire logic scl_oe,   // Controller clock enable
    input wire logic sda_m_o,  // Controller data out
    input wire logic sda_m_oe, // Controller data enable
    input wire logic sda_s_o,  // Device data out
    input wire logic sda_s_oe, // Device data enable
    input wire logic scl,      // Resolved clock
    input wire logic sda       // Resolved data
);
    localparam int NV_CYC = `DCAP_NV_PROG_CYC;
    logic [19:0] hi_q; // Cycles clock has been high
    logic [19:0] lo_q; // Cycles clock has been low
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // High-time counter, saturates so idle bus cannot wrap
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !scl) begin
            hi_q <= '0;
        end else if (hi_q != 20'hfffff) begin
            hi_q <= hi_q + 20'h1;
        end
    end
    // Low-time counter, long holds mark a programming wait
    always_ff @(posedge clk_sys) begin
        if (!reset_n || scl) begin
            lo_q <= '0;
        end else if (lo_q != 20'hfffff) begin
            lo_q <= lo_q + 20'h1;
        end
    end
    scl_high_min_a: assert property ($fell(scl) |-> hi_q >= 20'd20)
        else $error("clock high phase too short");
    scl_low_min_a: assert property ($rose(scl) |-> lo_q >= 20'd20)
        else $error("clock low phase too short");
    start_hold_a: assert property ($fell(sda) && scl |-> ##[1:60] $fell(scl))
        else $error("start not followed by clock");
    stop_idle_a: assert property ($rose(sda) && scl && $past(scl) |-> scl [*4])
        else $error("clock moved right after stop");
    dev_sda_stable_a: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
        else $error("device data changed with clock high");
    sda_contend_a: assert property (scl && $past(scl) |-> !(sda_s_oe && sda_m_oe))
        else $error("both ends drive data");
    nv_interval_a: assert property ($rose(scl) && lo_q > 20'd1000 |-> lo_q >= NV_CYC)
        else $error("programming hold shorter than interval");
    nv_stop_a: assert property ($rose(scl) && lo_q > 20'd1000 |-> ##[1:60] $rose(sda))
        else $error("programming hold not ended by stop");
endmodule : dcap_props
